// ===== design/vic_pkg.sv
package vic_pkg;
  // ---------------------------------------------
  // Sizes
  // ---------------------------------------------
  localparam int NUM_SRC = 30;
  localparam int NUM_TRAP = 4;
  localparam int DATA_W = 16;
  localparam int PC_W = 24;
  localparam int LVL_W = 4;
  localparam int PRIO_W = 3;
  localparam int NUM_FLAG_REGS = 3;
  localparam int NUM_PRIO_REGS = 12;
  localparam int TDIS_W = 14;
  // ---------------------------------------------
  // Register byte offsets
  // ---------------------------------------------
  localparam logic [7:0] OFF_FLAGS = 8'h00;
  localparam logic [7:0] OFF_ENABLES = 8'h0C;
  localparam logic [7:0] OFF_PRIO = 8'h20;
  localparam logic [7:0] OFF_CTRL_A = 8'h50;
  localparam logic [7:0] OFF_CTRL_B = 8'h54;
  localparam logic [7:0] OFF_CORE_CTRL = 8'h58;
  localparam logic [7:0] OFF_STATUS = 8'h5C;
  localparam logic [7:0] OFF_TDIS = 8'h60;
  localparam logic [7:0] PRIO_SPAN = 8'h30;
  // ---------------------------------------------
  // Field positions and masks
  // ---------------------------------------------
  localparam int NEST_DIS_BIT = 15;
  localparam int ALT_SEL_BIT = 15;
  localparam int TDIS_ACT_BIT = 14;
  localparam int ADDR_ERR_TRAP = 1;
  localparam int LVL_HI_BIT = 3;
  localparam int STATUS_LVL_LSB = 5;
  localparam logic [15:0] PRIO_MASK = 16'h7777;
  localparam logic [15:0] PRIO_LAST_MASK = 16'h0077;
  localparam logic [15:0] CTRL_A_MASK = 16'h800F;
  localparam logic [15:0] CTRL_B_MASK = 16'h8007;
  // ---------------------------------------------
  // Reset values
  // ---------------------------------------------
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [3:0] LVL_RESET = 4'h0;
  // ---------------------------------------------
  // Vector space and levels
  // ---------------------------------------------
  localparam logic [23:0] VEC_BASE_PRI = 24'h000004;
  localparam logic [23:0] VEC_BASE_ALT = 24'h000084;
  localparam logic [23:0] VEC_SPACE_LO = 24'h000004;
  localparam logic [23:0] VEC_SPACE_HI = 24'h0000FE;
  localparam logic [5:0] SRC_VEC_OFS = 6'h08;
  localparam logic [5:0] TRAP_VEC_OFS = 6'h01;
  localparam logic [2:0] TDIS_MAX_LVL = 3'h6;
  localparam logic [3:0] TRAP_LVL_TOP = 4'hF;
endpackage

// ===== design/vic_top.sv
module vic_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Event sources
  input wire logic [29:0] irq_src,
  input wire logic [3:0] trap_src,
  // Core request side
  output logic irq_req,
  output logic [5:0] irq_vec_num,
  output logic [23:0] irq_vec_addr,
  input wire logic irq_ack,
  input wire logic irq_return,
  input wire logic [3:0] restore_level,
  input wire logic instr_retire,
  // Program counter selector
  input wire logic [23:0] seq_pc,
  input wire logic vec_word_valid,
  input wire logic [23:0] vec_word,
  output logic [23:0] pc_next,
  output logic pc_load,
  // Address checks
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_addr,
  input wire logic jump_valid,
  input wire logic [23:0] jump_addr,
  // External trigger config
  output logic [2:0] ext_edge_polarity
);

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  // Address inside protected vector space
  function automatic logic in_vec_space(
    input logic [23:0] a);
    in_vec_space = (a >= vic_pkg::VEC_SPACE_LO)
      && (a <= vic_pkg::VEC_SPACE_HI);
  endfunction

  // Byte lane merge of a 16-bit register
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [15:0] nw,
    input logic [1:0] sel);
    merge16 = {sel[1] ? nw[15:8] : old[15:8],
      sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  logic [47:0] flag_bits; // Request flags
  logic [47:0] en_bits; // Enables
  logic [15:0] prio_reg [0:11]; // Priority nibbles
  logic [3:0] cpu_level; // Current level
  logic nest_dis; // Nesting disable
  logic [3:0] trap_flags; // Trap status
  logic alt_sel; // Alternate table select
  logic [13:0] tdis_count; // Timed disable left
  logic in_service; // Handler active
  logic req_trap; // Presented is a trap
  logic [4:0] req_idx; // Presented index
  logic [3:0] req_lvl; // Presented level

  // ---------------------------------------------
  // Bus decode
  // ---------------------------------------------
  wire bus_req = wb_cyc_i && wb_stb_i;
  // Write lands on the edge the master sees ack
  wire wr_fire = bus_req && wb_we_i && wb_ack_o;
  wire [15:0] wdat = wb_dat_i[15:0];
  wire [1:0] wsel = wb_sel_i[1:0];
  wire [7:0] prio_ofs = wb_adr_i - vic_pkg::OFF_PRIO;
  wire prio_hit = (wb_adr_i >= vic_pkg::OFF_PRIO)
    && (prio_ofs < vic_pkg::PRIO_SPAN)
    && (wb_adr_i[1:0] == 2'b00);
  wire [3:0] prio_idx = prio_ofs[5:2];
  wire [7:0] flag_ofs = wb_adr_i - vic_pkg::OFF_FLAGS;
  wire [7:0] en_ofs = wb_adr_i - vic_pkg::OFF_ENABLES;
  wire flag_hit = (flag_ofs < 8'h0C)
    && (wb_adr_i[1:0] == 2'b00);
  wire en_hit = (wb_adr_i >= vic_pkg::OFF_ENABLES)
    && (en_ofs < 8'h0C) && (wb_adr_i[1:0] == 2'b00);
  wire [1:0] flag_idx = flag_ofs[3:2];
  wire [1:0] en_idx = en_ofs[3:2];
  wire wr_ctrl_a = wr_fire
    && (wb_adr_i == vic_pkg::OFF_CTRL_A);
  wire wr_ctrl_b = wr_fire
    && (wb_adr_i == vic_pkg::OFF_CTRL_B);
  wire wr_core = wr_fire
    && (wb_adr_i == vic_pkg::OFF_CORE_CTRL);
  wire wr_status = wr_fire
    && (wb_adr_i == vic_pkg::OFF_STATUS);
  wire wr_tdis = wr_fire
    && (wb_adr_i == vic_pkg::OFF_TDIS);

  // ---------------------------------------------
  // Eligibility
  // ---------------------------------------------
  wire tdis_active = (tdis_count != 14'h0000);
  // Nested source take refused while a handler runs with nesting disabled
  wire nest_block = nest_dis && in_service;
  logic [2:0] src_lvl [0:29];
  logic [29:0] elig;
  logic [3:0] trap_elig;

  genvar gs;
  generate
    for (gs = 0; gs < vic_pkg::NUM_SRC; gs++)
    begin : g_src
      // Low three bits of the source nibble
      assign src_lvl[gs] =
        prio_reg[gs / 4][(gs % 4) * 4 +: 3];
      // Flag, enable, nonzero level above CPU
      assign elig[gs] = flag_bits[gs]
        && en_bits[gs]
        && (src_lvl[gs] != 3'h0)
        && ({1'b0, src_lvl[gs]} > cpu_level)
        && !nest_block
        && !(tdis_active
          && (src_lvl[gs] <= vic_pkg::TDIS_MAX_LVL));
    end
    for (gs = 0; gs < vic_pkg::NUM_TRAP; gs++)
    begin : g_trap
      // Traps sit above all maskable levels
      assign trap_elig[gs] = trap_flags[gs]
        && ((vic_pkg::TRAP_LVL_TOP - 4'(gs)) > cpu_level);
    end
  endgenerate

  // ---------------------------------------------
  // Arbiter
  // ---------------------------------------------
  logic win_valid;
  logic win_trap;
  logic [4:0] win_idx;
  logic [3:0] win_lvl;

  // Downward scan, ties keep the lower index
  always_comb
  begin
    win_valid = 1'b0;
    win_trap = 1'b0;
    win_idx = 5'h00;
    win_lvl = 4'h0;
    for (int s = vic_pkg::NUM_SRC - 1; s >= 0; s--)
    begin
      if (elig[s] && (!win_valid
        || ({1'b0, src_lvl[s]} >= win_lvl)))
      begin
        win_valid = 1'b1;
        win_idx = 5'(s);
        win_lvl = {1'b0, src_lvl[s]};
      end
    end
    // Traps override any maskable source
    for (int t = vic_pkg::NUM_TRAP - 1; t >= 0; t--)
    begin
      if (trap_elig[t])
      begin
        win_valid = 1'b1;
        win_trap = 1'b1;
        win_idx = 5'(t);
        win_lvl = vic_pkg::TRAP_LVL_TOP - 4'(t);
      end
    end
  end

  // ---------------------------------------------
  // Vector selection
  // ---------------------------------------------
  wire [5:0] win_vec = win_trap
    ? (vic_pkg::TRAP_VEC_OFS + 6'(win_idx))
    : (vic_pkg::SRC_VEC_OFS + 6'(win_idx));
  // Both tables live in the low vector space
  wire [23:0] vec_base = alt_sel
    ? vic_pkg::VEC_BASE_ALT
    : vic_pkg::VEC_BASE_PRI;
  wire [23:0] win_addr = vec_base
    + {17'h00000, win_vec, 1'b0};
  // Counter input selector
  wire [23:0] pc_sel = vec_word_valid
    ? vec_word : seq_pc;
  wire next_irq_req = win_valid && !irq_ack;

  // ---------------------------------------------
  // Address error detection
  // ---------------------------------------------
  wire fetch_err = fetch_valid
    && in_vec_space(fetch_addr);
  wire jump_err = jump_valid
    && in_vec_space(jump_addr);
  logic [3:0] trap_set;
  always_comb
  begin
    trap_set = trap_src;
    trap_set[vic_pkg::ADDR_ERR_TRAP] =
      trap_src[vic_pkg::ADDR_ERR_TRAP]
      || fetch_err || jump_err;
  end

  // ---------------------------------------------
  // Flags and enables
  // ---------------------------------------------
  logic [47:0] flag_wr;
  logic [47:0] en_wr;
  always_comb
  begin
    flag_wr = flag_bits;
    en_wr = en_bits;
    if (wr_fire && flag_hit)
      flag_wr[flag_idx * 16 +: 16] = merge16(
        flag_bits[flag_idx * 16 +: 16], wdat, wsel);
    if (wr_fire && en_hit)
      en_wr[en_idx * 16 +: 16] = merge16(
        en_bits[en_idx * 16 +: 16], wdat, wsel);
  end

  // A source event beats a same-cycle clear
  always_ff @(posedge mclk)
  begin
    if (reset)
      flag_bits <= {3{vic_pkg::REG_RESET}};
    else
      flag_bits <= flag_wr
        | {18'h00000, irq_src};
  end

  // Enables are software only
  always_ff @(posedge mclk)
  begin
    if (reset)
      en_bits <= {3{vic_pkg::REG_RESET}};
    else
      en_bits <= en_wr;
  end

  // ---------------------------------------------
  // Priority registers
  // ---------------------------------------------
  // Unimplemented nibble tops stay zero
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int k = 0; k < vic_pkg::NUM_PRIO_REGS; k++)
        prio_reg[k] <= vic_pkg::REG_RESET;
    end
    else if (wr_fire && prio_hit)
      prio_reg[prio_idx] <= merge16(
        prio_reg[prio_idx], wdat, wsel)
        & ((prio_idx == 4'hB)
          ? vic_pkg::PRIO_LAST_MASK
          : vic_pkg::PRIO_MASK);
  end

  // ---------------------------------------------
  // Control registers
  // ---------------------------------------------
  wire [15:0] ctrl_a_wr = merge16({nest_dis,
    11'h000, trap_flags}, wdat, wsel);
  wire [15:0] ctrl_b_wr = merge16({alt_sel,
    12'h000, ext_edge_polarity}, wdat, wsel);

  // Trap status: hardware set wins over clear
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      nest_dis <= 1'b0;
      trap_flags <= 4'h0;
    end
    else
    begin
      if (wr_ctrl_a)
        nest_dis <= ctrl_a_wr[vic_pkg::NEST_DIS_BIT];
      trap_flags <= (wr_ctrl_a ? ctrl_a_wr[3:0]
        : trap_flags) | trap_set;
    end
  end

  // Table select and external trigger config
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      alt_sel <= 1'b0;
      ext_edge_polarity <= 3'h0;
    end
    else if (wr_ctrl_b)
    begin
      alt_sel <= ctrl_b_wr[vic_pkg::ALT_SEL_BIT];
      ext_edge_polarity <= ctrl_b_wr[2:0];
    end
  end

  // Timed disable counts retired instructions
  always_ff @(posedge mclk)
  begin
    if (reset)
      tdis_count <= 14'h0000;
    else if (wr_tdis)
      tdis_count <= wdat[13:0];
    else if (instr_retire && tdis_active)
      tdis_count <= tdis_count - 14'h0001;
  end

  // ---------------------------------------------
  // CPU level and service state
  // ---------------------------------------------
  // Merged core control word, level bit 3 read back out of it
  wire [15:0] core_wr = merge16({12'h000, cpu_level[3], 3'h0},
    wdat, wsel);
  wire [3:0] lvl_from_core = {core_wr[vic_pkg::LVL_HI_BIT],
    cpu_level[2:0]};
  wire [15:0] st_wr = merge16({8'h00, cpu_level[2:0],
    5'h00}, wdat, wsel);
  wire [3:0] lvl_from_st = {cpu_level[3],
    st_wr[vic_pkg::STATUS_LVL_LSB +: 3]};

  // Core events first, then software writes
  always_ff @(posedge mclk)
  begin
    if (reset)
      cpu_level <= vic_pkg::LVL_RESET;
    else if (irq_ack)
      cpu_level <= req_lvl;
    else if (irq_return)
      cpu_level <= restore_level;
    else if (nest_dis)
      cpu_level <= cpu_level;
    else if (wr_core)
      cpu_level <= lvl_from_core;
    else if (wr_status)
      cpu_level <= lvl_from_st;
  end

  // One level of service tracking
  always_ff @(posedge mclk)
  begin
    if (reset)
      in_service <= 1'b0;
    else if (irq_ack)
      in_service <= 1'b1;
    else if (irq_return)
      in_service <= 1'b0;
  end

  // ---------------------------------------------
  // Core outputs
  // ---------------------------------------------
  // Request drops for a cycle after each take
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      irq_req <= 1'b0;
      irq_vec_num <= 6'h00;
      irq_vec_addr <= vic_pkg::VEC_BASE_PRI;
      req_trap <= 1'b0;
      req_idx <= 5'h00;
      req_lvl <= 4'h0;
    end
    else
    begin
      irq_req <= next_irq_req;
      irq_vec_num <= win_vec;
      irq_vec_addr <= win_addr;
      req_trap <= win_trap;
      req_idx <= win_idx;
      req_lvl <= win_lvl;
    end
  end

  // Counter selector output stage
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pc_next <= 24'h000000;
      pc_load <= 1'b0;
    end
    else
    begin
      pc_next <= pc_sel;
      pc_load <= vec_word_valid;
    end
  end

  // ---------------------------------------------
  // Read mux
  // ---------------------------------------------
  logic [15:0] rd_word;
  always_comb
  begin
    rd_word = 16'h0000;
    if (flag_hit)
      rd_word = flag_bits[flag_idx * 16 +: 16];
    else if (en_hit)
      rd_word = en_bits[en_idx * 16 +: 16];
    else if (prio_hit)
      rd_word = prio_reg[prio_idx];
    else
      case (wb_adr_i)
        vic_pkg::OFF_CTRL_A:
          rd_word = {nest_dis, 11'h000, trap_flags};
        vic_pkg::OFF_CTRL_B:
          rd_word = {alt_sel, tdis_active,
            11'h000, ext_edge_polarity};
        vic_pkg::OFF_CORE_CTRL:
          rd_word = {12'h000, cpu_level[3], 3'h0};
        vic_pkg::OFF_STATUS:
          rd_word = {8'h00, cpu_level[2:0], 5'h00};
        vic_pkg::OFF_TDIS:
          rd_word = {2'b00, tdis_count};
        // Unmapped reads return zero
        default:
          rd_word = 16'h0000;
      endcase
  end

  // ---------------------------------------------
  // Bus answer
  // ---------------------------------------------
  // One wait state, ack lasts a single cycle
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req && !wb_ack_o;
      wb_dat_o <= {16'h0000, rd_word};
    end
  end

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_flag_set_wins: assert property (
    |irq_src |=> ((flag_bits[29:0] & $past(irq_src))
      == $past(irq_src)))
    else $error("Source event lost from flag");
  a_win_enabled: assert property (
    win_valid && !win_trap |->
      en_bits[win_idx] && flag_bits[win_idx])
    else $error("Disabled source won");
  a_zero_level: assert property (
    win_valid && !win_trap |-> win_lvl != 4'h0)
    else $error("Level zero source won");
  a_above_cpu: assert property (
    win_valid |-> win_lvl > cpu_level)
    else $error("Winner not above CPU level");
  a_nest_block: assert property (
    nest_dis && in_service |-> !(win_valid && !win_trap))
    else $error("Nested take while disabled");
  a_level_frozen: assert property (
    nest_dis && (wr_core || wr_status)
      && !irq_ack && !irq_return |=> $stable(cpu_level))
    else $error("CPU level written under nest disable");
  a_timed_block: assert property (
    tdis_active && win_valid && !win_trap
      |-> win_lvl > 4'h6)
    else $error("Low level taken in timed disable");
  a_pc_vector: assert property (
    vec_word_valid |=> pc_load && pc_next == $past(vec_word))
    else $error("Vector word not loaded");
  a_fetch_trap: assert property (
    fetch_valid && fetch_addr >= 24'h000004
      && fetch_addr <= 24'h0000FE |=> trap_flags[1])
    else $error("Vector fetch not trapped");
  a_jump_trap: assert property (
    jump_valid && in_vec_space(jump_addr) |=> trap_flags[1])
    else $error("Jump into vectors not trapped");
  a_vec_range: assert property (
    irq_req |-> irq_vec_addr >= 24'h000004
      && irq_vec_addr <= 24'h0000FE)
    else $error("Vector address outside table");
  // Presented number must match the latched source index
  a_vec_number: assert property (
    irq_req && !req_trap |->
      irq_vec_num == vic_pkg::SRC_VEC_OFS + 6'(req_idx))
    else $error("Vector number does not match source");
  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("Ack held two cycles");

  c_trap_take: cover property (irq_req && req_trap ##1 irq_ack);
  c_src_take: cover property (irq_req && !req_trap ##1 irq_ack);
  c_timed: cover property (tdis_active ##1 !tdis_active);
  c_nested: cover property (in_service && irq_req && !nest_dis);

endmodule

// ===== testbench/vic_core_model.sv
module vic_core_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Request seen from the controller
  input wire logic irq_req,
  input wire logic [5:0] irq_vec_num,
  input wire logic [3:0] ack_delay,
  // Core side answers
  output logic irq_ack,
  output logic vec_word_valid,
  output logic [23:0] vec_word,
  output logic [23:0] seq_pc
);
  timeunit 1ns;
  timeprecision 100ps;
  // Cycles a request has stood unanswered
  logic [3:0] wait_cnt;
  // ----
  // Core acceptance and vector fetch
  // ----
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      irq_ack <= 1'b0;
      vec_word_valid <= 1'b0;
      vec_word <= 24'h000000;
      seq_pc <= 24'h000100;
      wait_cnt <= 4'h0;
    end
    else
    begin
      // Plain fetch address steps on
      seq_pc <= seq_pc + 24'h000002;
      // Vector word one cycle after the take
      vec_word_valid <= irq_ack;
      // Idle bus toggles so a stale word never looks valid
      vec_word <= irq_ack ? 24'h001000 + {18'h0, irq_vec_num} : ~vec_word;
      // Ack only while a request stands, after the chosen wait
      irq_ack <= !irq_ack && irq_req && wait_cnt == ack_delay;
      wait_cnt <= (irq_req && !irq_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// ===== testbench/vectored_interrupt_controller_bench.sv
module vectored_interrupt_controller_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Stimulus and observed signals
  // ----
  logic mclk = 1'b0, reset = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [29:0] irq_src = 30'h0;
  logic [3:0] trap_src = 4'h0, ack_delay = 4'h0;
  logic irq_req, irq_ack, irq_return = 1'b0, instr_retire = 1'b0;
  logic vec_word_valid, pc_load, fetch_valid = 1'b0, jump_valid = 1'b0;
  logic [5:0] irq_vec_num;
  logic [23:0] irq_vec_addr, seq_pc, vec_word, pc_next;
  logic [23:0] fetch_addr = 24'h0, jump_addr = 24'h0;
  logic [2:0] ext_edge_polarity;
  // Counters and random state
  int fail_count = 0, compares = 0;
  logic [31:0] r = 32'hF100;
  // Levels the bench wrote per source
  logic [2:0] lv [30];
  // Reset value probes, last one unmapped
  logic [7:0] offs [8] = '{8'h00, 8'h0C, 8'h20, 8'h4C, 8'h50, 8'h54, 8'h5C, 8'h80};
  // Address check probes around the vector space edges
  logic [23:0] aea [4] = '{24'h000003, 24'h000004, 24'h0000FE, 24'h0000FF};

  vic_top dut (.mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h3), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_src(irq_src), .trap_src(trap_src),
    .irq_req(irq_req), .irq_vec_num(irq_vec_num), .irq_vec_addr(irq_vec_addr),
    .irq_ack(irq_ack), .irq_return(irq_return), .restore_level(4'h0),
    .instr_retire(instr_retire), .seq_pc(seq_pc), .vec_word_valid(vec_word_valid),
    .vec_word(vec_word), .pc_next(pc_next), .pc_load(pc_load), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .jump_valid(jump_valid), .jump_addr(jump_addr),
    .ext_edge_polarity(ext_edge_polarity));

  vic_core_model core (.mclk(mclk), .reset(reset), .irq_req(irq_req),
    .irq_vec_num(irq_vec_num), .ack_delay(ack_delay), .irq_ack(irq_ack),
    .vec_word_valid(vec_word_valid), .vec_word(vec_word), .seq_pc(seq_pc));

  // 4 ns period
  always #2 mclk = ~mclk;

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected winner: highest level, lowest index on ties
  function automatic int win(input logic [29:0] f);
    int b;
    b = -1;
    for (int s = 0; s < 30; s++)
      if (f[s] && lv[s] != 3'h0 && (b < 0 || lv[s] > lv[b]))
        b = s;
    return b;
  endfunction
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Classic cycle; a hang is cut by the watchdog
  task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    do
      @(posedge mclk);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(name, {8'h00, e}, {8'h00, q});
  endtask
  // Wait for the take, then vector and counter load
  task automatic svc(input logic [5:0] num, input logic [23:0] base);
    do
      @(posedge mclk);
    while (irq_ack !== 1'b1);
    chk("vector number", {18'h0, num}, {18'h0, irq_vec_num});
    chk("vector address", base + {17'h0, num, 1'b0}, irq_vec_addr);
    repeat (2) @(posedge mclk);
    chk("counter load", 24'h001000 + {18'h0, num}, pc_next);
    chk("load strobe", 24'h1, {23'h0, pc_load});
  endtask
  task automatic ret();
    @(posedge mclk);
    irq_return <= 1'b1;
    @(posedge mclk);
    irq_return <= 1'b0;
  endtask
  task automatic pulse(input logic [29:0] s);
    irq_src <= s;
    @(posedge mclk);
    irq_src <= 30'h0;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run is under two thousand cycles; allow ample margin
  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    complete_run();
  end

  // ----
  // Main sequence
  // ----
  initial
  begin
    logic [29:0] en;
    logic [29:0] src;
    logic alt;
    logic [2:0] pol;
    int w;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    wr(8'h80, 16'hFFFF);
    foreach (offs[i])
      rchk("reset value", offs[i], 16'h0000);
    wr(vic_pkg::OFF_PRIO, 16'hFFFF);
    rchk("priority nibble", vic_pkg::OFF_PRIO, 16'h7777);
    wr(8'h4C, 16'hFFFF);
    rchk("last priority", 8'h4C, 16'h0077);
    // Random levels, enables and events
    for (int it = 0; it < 16; it++)
    begin
      r = lfsr(r);
      alt = r[0];
      pol = r[7:5];
      ack_delay <= r[4:1];
      wr(vic_pkg::OFF_CTRL_B, {alt, 12'h000, pol});
      for (int k = 0; k < 8; k++)
      begin
        r = lfsr(r);
        wr(vic_pkg::OFF_PRIO + 8'(4 * k), r[15:0]);
        for (int j = 0; j < 4; j++)
          if (4 * k + j < 30)
            lv[4 * k + j] = r[4 * j +: 3];
      end
      chk("edge polarity", {21'h0, pol}, {21'h0, ext_edge_polarity});
      r = lfsr(r);
      en = r[29:0];
      r = lfsr(r);
      en &= r[29:0];
      r = lfsr(r);
      src = r[29:0];
      r = lfsr(r);
      src &= r[29:0];
      wr(vic_pkg::OFF_ENABLES, en[15:0]);
      wr(vic_pkg::OFF_ENABLES + 8'h04, {2'b00, en[29:16]});
      pulse(src);
      w = win(src & en);
      if (w >= 0)
        svc(6'(w + 8), alt ? vic_pkg::VEC_BASE_ALT : vic_pkg::VEC_BASE_PRI);
      else
      begin
        repeat (24) @(posedge mclk);
        chk("idle request", 24'h0, {23'h0, irq_req});
      end
      rchk("flags low", vic_pkg::OFF_FLAGS, src[15:0]);
      rchk("flags high", vic_pkg::OFF_FLAGS + 8'h04, {2'b00, src[29:16]});
      rchk("cpu level", vic_pkg::OFF_STATUS, w < 0 ? 16'h0000 : {8'h00, lv[w], 5'h00});
      wr(vic_pkg::OFF_FLAGS, 16'h0000);
      wr(vic_pkg::OFF_FLAGS + 8'h04, 16'h0000);
      ret();
    end
    // Traps, always above the maskable levels
    wr(vic_pkg::OFF_CTRL_B, 16'h0000);
    ack_delay <= 4'h0;
    for (int t = 0; t < 4; t++)
    begin
      trap_src <= 4'(1 << t);
      @(posedge mclk);
      trap_src <= 4'h0;
      svc(6'(t + 1), vic_pkg::VEC_BASE_PRI);
      rchk("trap flags", vic_pkg::OFF_CTRL_A, 16'(1 << t));
      rchk("level high bit", vic_pkg::OFF_CORE_CTRL, 16'h0008);
      wr(vic_pkg::OFF_CTRL_A, 16'h0000);
      ret();
    end
    // Fetch and jump at the vector space edges
    for (int i = 0; i < 4; i++)
    begin
      fetch_addr <= aea[i];
      jump_addr <= aea[i];
      fetch_valid <= ~i[0];
      jump_valid <= i[0];
      @(posedge mclk);
      fetch_valid <= 1'b0;
      jump_valid <= 1'b0;
      rchk("address error", vic_pkg::OFF_CTRL_A, (i == 1 || i == 2) ? 16'h0002 : 16'h0000);
      wr(vic_pkg::OFF_CTRL_A, 16'h0000);
      repeat (20) @(posedge mclk);
      ret();
    end
    // Timed disable holds back a level 6 source for three instructions
    ack_delay <= 4'hF;
    wr(vic_pkg::OFF_PRIO, 16'h0006);
    wr(vic_pkg::OFF_ENABLES, 16'h0003);
    wr(vic_pkg::OFF_TDIS, 16'h0003);
    rchk("timed disable on", vic_pkg::OFF_CTRL_B, 16'h4000);
    pulse(30'h1);
    repeat (24) @(posedge mclk);
    chk("blocked request", 24'h0, {23'h0, irq_req});
    repeat (3)
    begin
      instr_retire <= 1'b1;
      @(posedge mclk);
      instr_retire <= 1'b0;
      @(posedge mclk);
    end
    rchk("timed disable off", vic_pkg::OFF_CTRL_B, 16'h0000);
    svc(6'h08, vic_pkg::VEC_BASE_PRI);
    wr(vic_pkg::OFF_FLAGS, 16'h0000);
    ret();
    // Nesting disabled: level 7 waits behind level 3
    wr(vic_pkg::OFF_CTRL_A, 16'h8000);
    wr(vic_pkg::OFF_PRIO, 16'h0073);
    pulse(30'h1);
    svc(6'h08, vic_pkg::VEC_BASE_PRI);
    wr(vic_pkg::OFF_STATUS, 16'h00E0);
    rchk("frozen level", vic_pkg::OFF_STATUS, 16'h0060);
    pulse(30'h2);
    repeat (24) @(posedge mclk);
    chk("nested request", 24'h0, {23'h0, irq_req});
    wr(vic_pkg::OFF_FLAGS, 16'h0002);
    ret();
    svc(6'h09, vic_pkg::VEC_BASE_PRI);
    wr(vic_pkg::OFF_FLAGS, 16'h0000);
    wr(vic_pkg::OFF_CTRL_A, 16'h0000);
    ret();
    complete_run();
  end
endmodule
